// ===== core/cvs_blank_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "cvs_params.svh"

module cvs_blank_timer #(
  parameter int CYCLES = `CVS_BLANK_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      blank
);
  import cvs_pkg::*;

  localparam logic [`CVS_BLANK_CNT_W-1:0] LOAD_VAL = `CVS_BLANK_CNT_W'(CYCLES - 1);

  logic [`CVS_BLANK_CNT_W-1:0] count;

  // ****************************************************************
  // Countdown: blank stays high for exactly CYCLES clocks after the last start.
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      blank <= 1'b0;
    end else if (start) begin
      count <= LOAD_VAL;
      blank <= 1'b1;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end else begin
      blank <= 1'b0;
    end
  end

  property p_blank_start;
    @(posedge clk) disable iff (!rst_n)
    start |=> blank && (count == LOAD_VAL);
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("Blanking did not restart on write.");

  property p_blank_end;
    @(posedge clk) disable iff (!rst_n)
    ($fell(blank)) |-> ($past(count) == '0) && !$past(start);
  endproperty
  a_blank_end: assert property (p_blank_end) else $error("Blanking ended before its count ran out.");

endmodule : cvs_blank_timer

`default_nettype wire

// ===== core/cvs_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "cvs_params.svh"

// Operation
// - buck3 code bits 5-0, reset 0Ch, two-slope table
// - buck-boost register at 19h, resets to B2h
// - buck-boost code bits 5-0, reset 32h, table
// - buck-boost codes above 34h are reserved
// - bit 7 enables light-load pulse skipping
// - locked writes leave the register unchanged
// - each accepted buck-boost write blanks supervision 5 ms
// - strap input selects the power-up defaults
module cvs_regs #(
  parameter int BLANK_CYCLES = `CVS_BLANK_CYCLES
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           wr_en,
  input  wire logic           rd_en,
  input  wire logic [7:0]     addr,
  input  wire cvs_pkg::cvs_byte_t wdata,
  input  wire logic           write_unlocked,
  input  wire logic           strap_resistor_select,
  output cvs_pkg::cvs_byte_t  rdata,
  output logic                rd_valid,
  output logic                ready,
  output cvs_pkg::cvs_code_t  buck3_voltage_code,
  output cvs_pkg::cvs_code_t  buckboost_voltage_code,
  output logic                light_load_skip_enable,
  output logic                buckboost_code_reserved,
  output cvs_pkg::cvs_mv_t    buck3_mv,
  output cvs_pkg::cvs_mv_t    buckboost_mv,
  output logic                buck3_supervision_blank,
  output logic                buckboost_supervision_blank
);
  import cvs_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction : addr_hit

  function automatic cvs_mv_t buck3_code_mv(input cvs_code_t c);
    cvs_mv_t cx;
    cx = {6'h00, c};
    if (c <= `CVS_BUCK3_LOW_LAST) begin
      return `CVS_BUCK3_LOW_BASE + `CVS_STEP_FINE * cx;
    end
    return `CVS_BUCK3_HIGH_BASE + `CVS_STEP_COARSE * (cx - {6'h00, `CVS_BUCK3_HIGH_FIRST});
  endfunction : buck3_code_mv

  function automatic cvs_mv_t buckboost_code_mv(input cvs_code_t c);
    cvs_mv_t cx;
    cx = {6'h00, c};
    if (c > `CVS_BB_CODE_MAX) begin
      return 12'h000;
    end
    if (c <= `CVS_BB_LOW_LAST) begin
      return `CVS_BB_LOW_BASE + `CVS_STEP_FINE * cx;
    end
    return `CVS_BB_HIGH_BASE + `CVS_STEP_COARSE * (cx - {6'h00, `CVS_BB_HIGH_FIRST});
  endfunction : buckboost_code_mv

  // ****************************************************************
  // Strap synchroniser and start-up sequence
  // ****************************************************************
  logic      strap_meta;
  logic      strap_sync;
  cvs_init_t init_state;
  logic      buckboost_wr;
  logic      buck3_wr;
  logic      buckboost_accept;
  logic      buck3_accept;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end else begin
      strap_meta <= strap_resistor_select;
      strap_sync <= strap_meta;
    end
  end

  // The strap is only trusted once it has passed both synchroniser stages.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_state <= CVS_INIT_SYNC1;
    end else begin
      case (init_state)
        CVS_INIT_SYNC1: init_state <= CVS_INIT_SYNC2;
        CVS_INIT_SYNC2: init_state <= CVS_INIT_LOAD;
        CVS_INIT_LOAD:  init_state <= CVS_INIT_RUN;
        CVS_INIT_RUN:   init_state <= CVS_INIT_RUN;
        default:        init_state <= CVS_INIT_SYNC1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
    end else begin
      ready <= (init_state == CVS_INIT_LOAD) || (init_state == CVS_INIT_RUN);
    end
  end

  // ****************************************************************
  // Write qualification
  // ****************************************************************
  assign buckboost_wr     = wr_en && addr_hit(addr, `CVS_BUCKBOOST_ADDR);
  assign buck3_wr         = wr_en && addr_hit(addr, `CVS_BUCK3_ADDR);
  assign buckboost_accept = buckboost_wr && write_unlocked && (init_state == CVS_INIT_RUN);
  assign buck3_accept     = buck3_wr && write_unlocked && (init_state == CVS_INIT_RUN);

  // ****************************************************************
  // Buck-boost register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      light_load_skip_enable <= `CVS_BUCKBOOST_SKIP_RST;
      buckboost_voltage_code <= `CVS_BUCKBOOST_CODE_RST;
    end else if (init_state == CVS_INIT_LOAD) begin
      if (strap_sync) begin
        buckboost_voltage_code <= `CVS_BUCKBOOST_CODE_STRAP;
      end
    end else if (buckboost_accept) begin
      light_load_skip_enable <= wdata[`CVS_SKIP_BIT];
      buckboost_voltage_code <= wdata[`CVS_CODE_MSB:`CVS_CODE_LSB];
    end
  end

  // ****************************************************************
  // Buck3 voltage code
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buck3_voltage_code <= `CVS_BUCK3_CODE_RST;
    end else if (init_state == CVS_INIT_LOAD) begin
      if (strap_sync) begin
        buck3_voltage_code <= `CVS_BUCK3_CODE_STRAP;
      end
    end else if (buck3_accept) begin
      buck3_voltage_code <= wdata[`CVS_CODE_MSB:`CVS_CODE_LSB];
    end
  end

  // ****************************************************************
  // Decoded set points
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buck3_mv                <= 12'h000;
      buckboost_mv            <= 12'h000;
      buckboost_code_reserved <= 1'b0;
    end else begin
      buck3_mv                <= buck3_code_mv(buck3_voltage_code);
      buckboost_mv            <= buckboost_code_mv(buckboost_voltage_code);
      buckboost_code_reserved <= buckboost_voltage_code > `CVS_BB_CODE_MAX;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata    <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        if (addr_hit(addr, `CVS_BUCKBOOST_ADDR)) begin
          rdata <= {light_load_skip_enable, 1'b0, buckboost_voltage_code};
        end else if (addr_hit(addr, `CVS_BUCK3_ADDR)) begin
          rdata <= {2'h0, buck3_voltage_code};
        end else begin
          rdata <= 8'h00;
        end
      end
    end
  end

  // ****************************************************************
  // Supervision blanking after accepted writes
  // ****************************************************************
  cvs_blank_timer #(
    .CYCLES (BLANK_CYCLES)
  ) u_buckboost_blank (
    .clk   (clk),
    .rst_n (rst_n),
    .start (buckboost_accept),
    .blank (buckboost_supervision_blank)
  );

  cvs_blank_timer #(
    .CYCLES (BLANK_CYCLES)
  ) u_buck3_blank (
    .clk   (clk),
    .rst_n (rst_n),
    .start (buck3_accept),
    .blank (buck3_supervision_blank)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_bb_reset;
    @(posedge clk) disable iff (!rst_n)
    (init_state == CVS_INIT_SYNC2) |->
      ({light_load_skip_enable, 1'b0, buckboost_voltage_code} == `CVS_BUCKBOOST_RESET);
  endproperty
  a_bb_reset: assert property (p_bb_reset) else $error("Buck-boost reset value wrong.");

  property p_b3_reset;
    @(posedge clk) disable iff (!rst_n)
    (init_state == CVS_INIT_SYNC2) |-> (buck3_voltage_code == `CVS_BUCK3_CODE_RST);
  endproperty
  a_b3_reset: assert property (p_b3_reset) else $error("Buck3 reset code wrong.");

  property p_b3_table;
    @(posedge clk) disable iff (!rst_n)
    ($past(buck3_voltage_code) == 6'h3F) |-> (buck3_mv == 12'hD48);
  endproperty
  a_b3_table: assert property (p_b3_table) else $error("Buck3 top code not 3400 mV.");

  property p_bb_table;
    @(posedge clk) disable iff (!rst_n)
    ($past(buckboost_voltage_code) == 6'h23) |-> (buckboost_mv == 12'h9F6);
  endproperty
  a_bb_table: assert property (p_bb_table) else $error("Buck-boost code 23h not 2550 mV.");

  property p_bb_reserved;
    @(posedge clk) disable iff (!rst_n)
    ($past(buckboost_voltage_code) > 6'h34) |-> buckboost_code_reserved && (buckboost_mv == 12'h000);
  endproperty
  a_bb_reserved: assert property (p_bb_reserved) else $error("Reserved code not flagged.");

  property p_skip_write;
    @(posedge clk) disable iff (!rst_n)
    buckboost_accept |=> (light_load_skip_enable == $past(wdata[7]))
      && (buckboost_voltage_code == $past(wdata[5:0]));
  endproperty
  a_skip_write: assert property (p_skip_write) else $error("Accepted write not stored.");

  property p_locked;
    @(posedge clk) disable iff (!rst_n)
    (buckboost_wr && !write_unlocked) |=> $stable(buckboost_voltage_code) && $stable(light_load_skip_enable);
  endproperty
  a_locked: assert property (p_locked) else $error("Locked write changed register.");

  property p_blank_follows;
    @(posedge clk) disable iff (!rst_n)
    buckboost_accept |=> buckboost_supervision_blank [*2];
  endproperty
  a_blank_follows: assert property (p_blank_follows) else $error("No blanking after write.");

  property p_strap;
    @(posedge clk) disable iff (!rst_n)
    (init_state == CVS_INIT_LOAD && strap_sync) |=>
      (buckboost_voltage_code == `CVS_BUCKBOOST_CODE_STRAP) && (buck3_voltage_code == `CVS_BUCK3_CODE_STRAP);
  endproperty
  a_strap: assert property (p_strap) else $error("Strap defaults not loaded.");

  property p_read_back;
    @(posedge clk) disable iff (!rst_n)
    (rd_en && addr_hit(addr, `CVS_BUCKBOOST_ADDR)) |=>
      rd_valid && (rdata == {$past(light_load_skip_enable), 1'b0, $past(buckboost_voltage_code)})
      && (rdata[6] == 1'b0);
  endproperty
  a_read_back: assert property (p_read_back) else $error("Read-back differs from stored value.");

endmodule : cvs_regs

`default_nettype wire

// ===== include/cvs_params.svh
`ifndef CVS_PARAMS_SVH
`define CVS_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define CVS_ADDR_W            8
`define CVS_DATA_W            8
`define CVS_BUCK3_ADDR        8'h18
`define CVS_BUCKBOOST_ADDR    8'h19

// ****************************************************************
// Field layout
// ****************************************************************
`define CVS_SKIP_BIT          7
`define CVS_RSV_BIT           6
`define CVS_CODE_MSB          5
`define CVS_CODE_LSB          0

// ****************************************************************
// Reset values
// ****************************************************************
`define CVS_BUCKBOOST_RESET   8'hB2
`define CVS_BUCKBOOST_SKIP_RST 1'h1
`define CVS_BUCKBOOST_CODE_RST 6'h32
`define CVS_BUCK3_CODE_RST    6'h0C
`define CVS_BUCKBOOST_CODE_STRAP 6'h1E
`define CVS_BUCK3_CODE_STRAP  6'h08

// ****************************************************************
// Voltage code tables, in millivolts
// ****************************************************************
`define CVS_BUCK3_LOW_LAST    6'h1A
`define CVS_BUCK3_HIGH_FIRST  6'h1B
`define CVS_BUCK3_LOW_BASE    12'h384
`define CVS_BUCK3_HIGH_BASE   12'h640
`define CVS_BB_LOW_LAST       6'h0F
`define CVS_BB_HIGH_FIRST     6'h10
`define CVS_BB_LOW_BASE       12'h497
`define CVS_BB_HIGH_BASE      12'h640
`define CVS_BB_CODE_MAX       6'h34
`define CVS_STEP_FINE         12'h019
`define CVS_STEP_COARSE       12'h032

// ****************************************************************
// Timing
// ****************************************************************
`define CVS_CLK_KHZ           50000
`define CVS_BLANK_MS          5
`define CVS_BLANK_CYCLES      (`CVS_BLANK_MS * `CVS_CLK_KHZ)
`define CVS_BLANK_CNT_W       18

`endif

// ===== include/cvs_pkg.sv
`default_nettype none

package cvs_pkg;

  typedef logic [5:0]  cvs_code_t;
  typedef logic [11:0] cvs_mv_t;
  typedef logic [7:0]  cvs_byte_t;

  typedef enum logic [1:0] {
    CVS_INIT_SYNC1,
    CVS_INIT_SYNC2,
    CVS_INIT_LOAD,
    CVS_INIT_RUN
  } cvs_init_t;

endpackage : cvs_pkg

`default_nettype wire

// ===== test/cvs_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Host side of the register port
// ****************************************************************
module cvs_host_model (
  input  wire logic               clk,
  input  wire cvs_pkg::cvs_byte_t rdata,
  input  wire logic               rd_valid,
  output logic                    wr_en,
  output logic                    rd_en,
  output logic [7:0]              addr,
  output cvs_pkg::cvs_byte_t      wdata,
  output logic                    write_unlocked
);
  import cvs_pkg::*;

  initial begin
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
    write_unlocked = 1'h0;
  end

  // Released address and data lines show the inverse of the last value so stale data is never sampled.
  // The converter is taken as off here, so the code may be retuned at any write.
  task automatic write_reg(input logic [7:0] a, input cvs_byte_t d, input logic unl);
    @(posedge clk);
    wr_en <= 1'h1;
    addr <= a;
    wdata <= d;
    write_unlocked <= unl;
    @(posedge clk);
    wr_en <= 1'h0;
    addr <= ~a;
    wdata <= ~d;
    write_unlocked <= 1'h0;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output cvs_byte_t d, output logic ok);
    @(posedge clk);
    rd_en <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'h0;
    addr <= ~a;
    @(negedge clk);
    ok = rd_valid;
    d = rdata;
  endtask : read_reg
endmodule : cvs_host_model

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "cvs_params.svh"

module testbench;
  import cvs_pkg::*;
  localparam int         blank_cycles = 20;
  localparam logic [7:0] bb_addr      = `CVS_BUCKBOOST_ADDR;
  localparam logic [7:0] b3_addr      = `CVS_BUCK3_ADDR;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        strap = 1'h0;
  wire logic   wr_en, rd_en, write_unlocked, rd_valid, ready, skip, rsv, bb_blank, b3_blank;
  wire logic [7:0] addr;
  cvs_byte_t   wdata, rdata;
  cvs_code_t   b3_code, bb_code;
  cvs_mv_t     b3_mv, bb_mv;
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          m_skip, m_bb, m_b3;
  integer      seed = 32'hA735F4C9;
  logic [15:0] tbl [9] = '{16'h1800, 16'h181A, 16'h181B, 16'h183F, 16'h190F, 16'h1910, 16'h1934,
                           16'h19F5, 16'h197F};

  cvs_host_model host (.clk(clk), .rdata(rdata), .rd_valid(rd_valid), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .write_unlocked(write_unlocked));

  cvs_regs #(.BLANK_CYCLES(blank_cycles)) u_cvs_regs (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .write_unlocked(write_unlocked),
    .strap_resistor_select(strap), .rdata(rdata), .rd_valid(rd_valid), .ready(ready),
    .buck3_voltage_code(b3_code), .buckboost_voltage_code(bb_code), .light_load_skip_enable(skip),
    .buckboost_code_reserved(rsv), .buck3_mv(b3_mv), .buckboost_mv(bb_mv),
    .buck3_supervision_blank(b3_blank), .buckboost_supervision_blank(bb_blank));

  initial begin
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Reference model and checks
  // ****************************************************************
  function automatic int exp_bb_mv(input int c);
    if (c <= 15) return 1175 + 25 * c;
    if (c <= 52) return 1600 + 50 * (c - 16);
    return 0;
  endfunction : exp_bb_mv

  function automatic int exp_b3_mv(input int c);
    if (c <= 26) return 900 + 25 * c;
    return 1600 + 50 * (c - 27);
  endfunction : exp_b3_mv

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic do_reset(input logic s, input int bb, input int b3);
    @(posedge clk);
    rst_n <= 1'h0;
    strap <= s;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    // Look at the outputs away from the edge that launches ready.
    @(negedge clk);
    m_skip = 1;
    m_bb = bb;
    m_b3 = b3;
  endtask : do_reset

  task automatic put(input logic [7:0] a, input cvs_byte_t d, input logic unl);
    host.write_reg(a, d, unl);
    if (unl !== 1'h1) return;
    if (a == bb_addr) begin
      m_skip = d[7];
      m_bb = d[5:0];
    end else if (a == b3_addr) begin
      m_b3 = d[5:0];
    end
  endtask : put

  task automatic check_all;
    cvs_byte_t d;
    logic      ok;
    host.read_reg(bb_addr, d, ok);
    chk("rd_valid", 12'h001, {11'h000, ok});
    chk("bb_read", {4'h0, m_skip[0], 1'h0, m_bb[5:0]}, {4'h0, d});
    host.read_reg(b3_addr, d, ok);
    chk("b3_read", m_b3[11:0], {4'h0, d});
    chk("skip", m_skip[11:0], {11'h000, skip});
    chk("bb_code", m_bb[11:0], {6'h00, bb_code});
    chk("b3_code", m_b3[11:0], {6'h00, b3_code});
    chk("bb_mv", exp_bb_mv(m_bb), bb_mv);
    chk("b3_mv", exp_b3_mv(m_b3), b3_mv);
    chk("bb_rsv", {11'h000, m_bb > 52}, {11'h000, rsv});
  endtask : check_all

  task automatic blank_len(input logic [7:0] a, input logic unl, input int exp);
    int n;
    n = 0;
    repeat (2 * blank_cycles) @(negedge clk);
    put(a, 8'h85, unl);
    repeat (2 * blank_cycles) begin
      @(negedge clk);
      n += (a == bb_addr) ? int'(bb_blank) : int'(b3_blank);
    end
    chk("blank_len", exp, n);
  endtask : blank_len

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    cvs_byte_t  d;
    logic       ok;
    logic [7:0] a;
    do_reset(1'h0, 'h32, 'h0C);
    chk("ready", 12'h001, {11'h000, ready});
    check_all();
    $display("test defaults done");
    foreach (tbl[i]) begin
      put(tbl[i][15:8], tbl[i][7:0], 1'h1);
      check_all();
    end
    $display("test boundary codes done");
    for (int i = 0; i < 16; i++) begin
      a = ($random(seed) & 1) ? bb_addr : b3_addr;
      d = $random(seed);
      d[5:0] = d[5:0] % 53;
      put(($random(seed) % 4 == 0) ? 8'h20 : a, d, $random(seed) & 1);
      check_all();
    end
    host.read_reg(8'h20, d, ok);
    chk("unmapped", 12'h000, {4'h0, d});
    $display("test random writes done");
    blank_len(bb_addr, 1'h1, blank_cycles);
    blank_len(bb_addr, 1'h0, 0);
    blank_len(b3_addr, 1'h1, blank_cycles);
    check_all();
    $display("test blanking done");
    do_reset(1'h1, `CVS_BUCKBOOST_CODE_STRAP, `CVS_BUCK3_CODE_STRAP);
    check_all();
    $display("test strap defaults done");
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
